// ==== sram_dev_model.sv ====
// Purpose: Behavioural 256K x 16 static RAM
// Assumes: Clock only times write ends mid-cycle
// Notes:   Undriven pins toggle so stale data never passes
`default_nettype none
module sram_dev_model
  import sram_host_pkg::*;
#(
  parameter int ACC_NS = 70
)(
  input  wire logic              clock,
  input  wire logic [ADDR_W-1:0] word_addr_in,
  input  wire sram_ctl_t         ctl,
  input  wire logic [DATA_W-1:0] host_o,
  input  wire logic [DATA_W-1:0] host_oe,
  output var  logic [DATA_W-1:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] noise = 16'h5A5A;
  logic [DATA_W-1:0] rd_d, lat_d;
  logic [ADDR_W-1:0] lat_a;
  logic [1:0]        lat_l;
  logic              wr_q = 1'b0;
  logic              act, rd_lo, rd_hi;
  always #30 noise = ~noise;
  // Drive only with select and gate low and strobe high
  assign act = !ctl.chip_sel_n && !ctl.out_gate_n && ctl.wr_strobe_n;
  assign rd_lo = act && !ctl.low_lane_sel_n;
  assign rd_hi = act && !ctl.high_lane_sel_n;
  assign #(ACC_NS) rd_d = mem[word_addr_in];
  always_comb
    for (int i = 0; i < DATA_W; i++)
      pins[i] = host_oe[i] ? host_o[i] : ((i < 8 ? rd_lo : rd_hi) ? rd_d[i] : noise[i]);
  // Store at the first falling clock edge after the strobe rises, with the pins latched at the falling edge before
  always @(negedge clock) begin
    if (wr_q && (ctl.chip_sel_n || ctl.wr_strobe_n)) begin
      if (!lat_l[0])
        mem[lat_a][7:0] = lat_d[7:0];
      if (!lat_l[1])
        mem[lat_a][15:8] = lat_d[15:8];
    end
    wr_q = !ctl.chip_sel_n && !ctl.wr_strobe_n;
    lat_a = word_addr_in;
    lat_d = pins;
    lat_l = {ctl.high_lane_sel_n, ctl.low_lane_sel_n};
  end
endmodule
`default_nettype wire

// ==== sram_host_ctrl.sv ====
// Purpose: Host-side controller driving an asynchronous 256K x 16 static RAM
// Assumes: One 20 MHz clock; speed grade chosen by a static input
// Notes:   Pins are driven from flops; data pins are split in/out/enable
`default_nettype none

module sram_host_ctrl
  import sram_host_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              slow_grade,
  input  wire logic              req_valid,
  input  wire sram_req_t         req,
  output var  logic              req_ready,
  output var  logic              rsp_valid,
  output var  logic [DATA_W-1:0] rsp_rdata,
  output var  logic [ADDR_W-1:0] word_addr_in,
  output var  sram_ctl_t         ctl,
  input  wire logic [DATA_W-1:0] data_pins_i,
  output var  logic [DATA_W-1:0] data_pins_o,
  output var  logic [DATA_W-1:0] data_pins_oe
);

  // Setup lets the address settle before any strobe falls; recovery holds it
  // one more cycle after the strobes rise, so a write ends on a quiet bus
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_READ,
    ST_WRITE,
    ST_RECOVER
  } state_t;

  state_t            state_q;
  logic              timer_load;
  logic [CYC_W-1:0]  timer_count;
  logic              timer_done;
  logic [1:0]        lanes_q;
  logic              is_write_q;
  logic [CYC_W-1:0]  rd_cyc;
  logic [CYC_W-1:0]  wp_cyc;
  logic [DATA_W-1:0] rd_sync1_q;
  logic [DATA_W-1:0] rd_sync2_q;
  logic              accept;

  // Byte lane enables (bit 1 upper, bit 0 lower) widened to one bit per pin
  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
    return {{8{lanes[1]}}, {8{lanes[0]}}};
  endfunction

  // Longer of two counts; one strobe phase has to meet both minimums at once
  function automatic logic [CYC_W-1:0] longer(input logic [CYC_W-1:0] a,
                                               input logic [CYC_W-1:0] b);
    return (a > b) ? a : b;
  endfunction

  // Grade picks the phase lengths; data is driven from the strobe's fall, so
  // the write pulse must also cover the data lead before the strobe rises
  assign rd_cyc = slow_grade ? RD_CYC_SLOW : RD_CYC_FAST;
  assign wp_cyc = slow_grade ? longer(WP_CYC_SLOW, DW_CYC_SLOW)
                             : longer(WP_CYC_FAST, DW_CYC_FAST);
  assign accept = req_valid && req_ready && (req.lanes != 2'h0);

  // One shared down counter paces setup and the strobe phase; only one phase runs at a time
  sram_host_timer sram_host_timer_inst (
    .clock (clock),
    .rstn  (rstn),
    .load  (timer_load),
    .count (timer_count),
    .done  (timer_done)
  );

  // Timer loads: setup, strobe phase, recovery
  // Setup and the strobe phase reload the counter on the edge at which their own count runs out
  always_comb begin
    timer_load  = 1'b0;
    timer_count = AS_CYC;
    case (state_q)
      ST_IDLE: begin
        timer_load  = accept;
        timer_count = AS_CYC;
      end
      ST_SETUP: begin
        timer_load  = timer_done;
        timer_count = is_write_q ? wp_cyc : rd_cyc;
      end
      ST_READ, ST_WRITE: begin
        timer_load  = timer_done;
        timer_count = AS_CYC;
      end
      default: begin
        timer_load  = 1'b0;
        timer_count = AS_CYC;
      end
    endcase
  end

  // Phase sequencer
  // Setup, read and write exits wait on done, so none can be cut shorter than its count; recovery always lasts one cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:    if (accept) state_q <= ST_SETUP;
        ST_SETUP:   if (timer_done) state_q <= is_write_q ? ST_WRITE : ST_READ;
        ST_READ:    if (timer_done) state_q <= ST_RECOVER;
        ST_WRITE:   if (timer_done) state_q <= ST_RECOVER;
        // Recovery keeps the address one cycle past the strobe rise
        ST_RECOVER: state_q <= ST_IDLE;
        default:    state_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture; address held from setup through recovery
  always_ff @(posedge clock) begin
    if (!rstn) begin
      word_addr_in <= '0;
      data_pins_o  <= '0;
      lanes_q      <= 2'h0;
      is_write_q   <= 1'b0;
    end else if (accept) begin
      word_addr_in <= req.addr;
      data_pins_o  <= req.wdata;
      lanes_q      <= req.lanes;
      is_write_q   <= req.write;
    end
  end

  // Control strobes, all solid levels from reset onward
  // Select, lanes and gate move on one edge together, so no pin is left
  // at an undefined level between phases
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctl <= CTL_IDLE;
    end else begin
      ctl <= CTL_IDLE;
      if ((state_q == ST_SETUP && timer_done) || (state_q == ST_READ && !timer_done) ||
          (state_q == ST_WRITE && !timer_done)) begin
        ctl.chip_sel_n      <= 1'b0;
        ctl.low_lane_sel_n  <= !lanes_q[0];
        ctl.high_lane_sel_n <= !lanes_q[1];
        ctl.out_gate_n      <= is_write_q;
        ctl.wr_strobe_n     <= !is_write_q;
      end
    end
  end

  // Drive data throughout the strobe, released one cycle after strobe rises
  // The late release gives hold time at the write end for one dead cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      data_pins_oe <= '0;
    end else if (state_q == ST_SETUP && is_write_q) begin
      data_pins_oe <= lane_mask(lanes_q);
    end else if (state_q == ST_RECOVER || state_q == ST_IDLE) begin
      data_pins_oe <= '0;
    end
  end

  // Two-stage sampling of the read data pins
  // The memory answers with no clock of its own; two flops keep a pin that
  // changes near the edge from reaching the response register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_sync1_q <= '0;
      rd_sync2_q <= '0;
    end else begin
      rd_sync1_q <= data_pins_i;
      rd_sync2_q <= rd_sync1_q;
    end
  end

  // Sample at recovery: the pins were taken two edges back, one cycle after the strobe fell
  // Unselected lanes read as zero, since the pins there carry no data
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state_q == ST_RECOVER);
      if (state_q == ST_RECOVER && !is_write_q) begin
        rsp_rdata <= rd_sync2_q & lane_mask(lanes_q);
      end
    end
  end

  // Ready only while idle and no new request is taken this cycle
  // Registered, so a take and the next ready can never fall on one edge
  always_ff @(posedge clock) begin
    if (!rstn) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_q == ST_IDLE) && !accept;
    end
  end

endmodule

`default_nettype wire

// ==== sram_host_pkg.sv ====
// Purpose: Shared constants and carriers for the static RAM host controller
// Assumes: 20 MHz system clock, 18-bit word address, 16-bit data
// Notes:   Strobe times are held in ns and turned into cycle counts here
`default_nettype none

package sram_host_pkg;

  localparam int unsigned ADDR_W          = 18;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned CLK_PERIOD_NS   = 50;

  // Read and write cycle minimum, fast and slow grade
  localparam int unsigned T_CYCLE_FAST_NS = 55;
  localparam int unsigned T_CYCLE_SLOW_NS = 70;
  // Write strobe low minimum
  localparam int unsigned T_WP_FAST_NS    = 45;
  localparam int unsigned T_WP_SLOW_NS    = 55;
  // Data valid before end of write (data_overlap)
  localparam int unsigned T_DW_FAST_NS    = 25;
  localparam int unsigned T_DW_SLOW_NS    = 30;
  // Address set-up before write begins
  localparam int unsigned T_AS_NS         = 0;

  // Least times round up to whole cycles, never below one
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CYC_W           = 4;
  localparam logic [3:0]  RD_CYC_FAST     = 4'(ns_to_cyc(T_CYCLE_FAST_NS));
  localparam logic [3:0]  RD_CYC_SLOW     = 4'(ns_to_cyc(T_CYCLE_SLOW_NS));
  localparam logic [3:0]  WP_CYC_FAST     = 4'(ns_to_cyc(T_WP_FAST_NS));
  localparam logic [3:0]  WP_CYC_SLOW     = 4'(ns_to_cyc(T_WP_SLOW_NS));
  localparam logic [3:0]  DW_CYC_FAST     = 4'(ns_to_cyc(T_DW_FAST_NS));
  localparam logic [3:0]  DW_CYC_SLOW     = 4'(ns_to_cyc(T_DW_SLOW_NS));
  localparam logic [3:0]  AS_CYC          = 4'(ns_to_cyc(T_AS_NS));

  // Pin levels when idle
  localparam logic        STROBE_IDLE     = 1'b1;

  // User request: address, data, lane enables (active high), direction
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lanes;
    logic              write;
  } sram_req_t;

  // Control strobes toward the memory, all active low
  typedef struct packed {
    logic chip_sel_n;
    logic out_gate_n;
    logic wr_strobe_n;
    logic low_lane_sel_n;
    logic high_lane_sel_n;
  } sram_ctl_t;

  localparam sram_ctl_t CTL_IDLE = '{chip_sel_n: STROBE_IDLE, out_gate_n: STROBE_IDLE,
                                     wr_strobe_n: STROBE_IDLE, low_lane_sel_n: STROBE_IDLE,
                                     high_lane_sel_n: STROBE_IDLE};

endpackage

`default_nettype wire

// ==== sram_host_props.sv ====
// Purpose: Pin timing checks on the RAM host
// Assumes: 50 ns clock
// Notes:   Bound to sram_host_ctrl
`default_nettype none
module sram_host_props
  import sram_host_pkg::*;
(
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              slow_grade,
  input wire logic              req_valid,
  input wire sram_req_t         req,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [DATA_W-1:0] rsp_rdata,
  input wire logic [ADDR_W-1:0] word_addr_in,
  input wire sram_ctl_t         ctl,
  input wire logic [DATA_W-1:0] data_pins_i,
  input wire logic [DATA_W-1:0] data_pins_o,
  input wire logic [DATA_W-1:0] data_pins_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ADDR_W-1:0] addr_q;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Address of the last accepted request
  always_ff @(posedge clock)
    if (req_valid && req_ready && req.lanes != 2'h0)
      addr_q <= req.addr;
  a_idle_pins: assert property (req_ready |->
    ctl == CTL_IDLE && data_pins_oe == 16'h0000) else $error("pins busy when idle");
  a_addr_match: assert property (!ctl.chip_sel_n |-> word_addr_in == addr_q)
    else $error("address differs from request");
  a_read_len: assert property ($fell(ctl.out_gate_n) |=>
    !ctl.out_gate_n && !ctl.chip_sel_n) else $error("read strobe too short");
  a_cycle_addr: assert property ($fell(ctl.chip_sel_n) |=>
    $stable(word_addr_in)[*2]) else $error("cycle too short");
  a_pulse_slow: assert property ($fell(ctl.wr_strobe_n) && slow_grade |=>
    !ctl.wr_strobe_n) else $error("slow write pulse too short");
  a_data_lead: assert property (!ctl.wr_strobe_n |->
    data_pins_oe != 16'h0000 && $stable(data_pins_o)) else $error("data moves in write");
  a_addr_hold: assert property (!ctl.wr_strobe_n |->
    $stable(word_addr_in) ##1 $stable(word_addr_in)) else $error("address moves in write");
endmodule
bind sram_host_ctrl sram_host_props sram_host_props_inst (
  .clock        (clock),
  .rstn         (rstn),
  .slow_grade   (slow_grade),
  .req_valid    (req_valid),
  .req          (req),
  .req_ready    (req_ready),
  .rsp_valid    (rsp_valid),
  .rsp_rdata    (rsp_rdata),
  .word_addr_in (word_addr_in),
  .ctl          (ctl),
  .data_pins_i  (data_pins_i),
  .data_pins_o  (data_pins_o),
  .data_pins_oe (data_pins_oe)
);
`default_nettype wire

// ==== sram_host_timer.sv ====
// Purpose: Down counter that paces each strobe phase in whole clock cycles
// Assumes: Load and count share one clock; load wins over counting
// Notes:   done is a registered level, high while the count sits at zero
`default_nettype none

module sram_host_timer
  import sram_host_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             load,
  input  wire logic [CYC_W-1:0] count,
  output var  logic             done
);

  logic [CYC_W-1:0] cnt_q;

  // Loading count N makes done rise N-1 edges later, so the phase lasts N cycles
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= '0;
      done  <= 1'b1;
    end else if (load) begin
      cnt_q <= count - 4'h1;
      done  <= (count <= 4'h1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 4'h1;
      done  <= (cnt_q == 4'h1);
    end
  end

endmodule

`default_nettype wire

// ==== tb_sram_host_ctrl.sv ====
// Purpose: Self-checking bench for the RAM host
// Assumes: 50 ns clock, RAM model on the pins
// Notes:   Fast grade first, then slow
`default_nettype none
module tb_sram_host_ctrl
  import sram_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clock = 1'b0;
  logic              rstn = 1'b0;
  logic              slow_grade = 1'b0;
  logic              req_valid = 1'b0;
  sram_req_t         req = '0;
  logic              req_ready, rsp_valid;
  logic [DATA_W-1:0] rsp_rdata, data_pins_i, data_pins_o, data_pins_oe, q;
  logic [ADDR_W-1:0] word_addr_in;
  sram_ctl_t         ctl;
  int                mismatches = 0;
  int                total_checks = 0;
  int                cyc = 0;
  always #25 clock = ~clock;
  sram_host_ctrl sram_host_ctrl_inst (
    .clock        (clock),
    .rstn         (rstn),
    .slow_grade   (slow_grade),
    .req_valid    (req_valid),
    .req          (req),
    .req_ready    (req_ready),
    .rsp_valid    (rsp_valid),
    .rsp_rdata    (rsp_rdata),
    .word_addr_in (word_addr_in),
    .ctl          (ctl),
    .data_pins_i  (data_pins_i),
    .data_pins_o  (data_pins_o),
    .data_pins_oe (data_pins_oe)
  );
  sram_dev_model sram_dev_model_inst (
    .clock        (clock),
    .word_addr_in (word_addr_in),
    .ctl          (ctl),
    .host_o       (data_pins_o),
    .host_oe      (data_pins_oe),
    .pins         (data_pins_i)
  );
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // The whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One transfer, bounded waits for the take and the answer
  task automatic xfer(input logic w, input logic [1:0] ln, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{addr: a, wdata: d, lanes: ln, write: w};
    do @(posedge clock); while (req_ready !== 1'b1 && ++n < 40);
    req_valid <= 1'b0;
    do @(posedge clock); while (rsp_valid !== 1'b1 && ++n < 40);
    q = rsp_rdata;
    check("answer", 16'(rsp_valid), 16'h0001);
    check("addr", 16'(word_addr_in !== a), 16'h0000);
  endtask
  task automatic t_reset();
    check("ctl idle", 16'(ctl), 16'(CTL_IDLE));
    check("oe idle", data_pins_oe, 16'h0000);
  endtask
  // Word, then each lane alone, read back under every lane code
  task automatic t_lanes(input logic [ADDR_W-1:0] a);
    xfer(1'b1, 2'h3, a, 16'h1234);
    xfer(1'b0, 2'h3, a, 16'h0000);
    check("word", q, 16'h1234);
    xfer(1'b1, 2'h1, a, 16'hFFAB);
    xfer(1'b0, 2'h3, a, 16'h0000);
    check("low wr", q, 16'h12AB);
    xfer(1'b1, 2'h2, a, 16'hCDFF);
    xfer(1'b0, 2'h1, a, 16'h0000);
    check("low rd", q, 16'h00AB);
    xfer(1'b0, 2'h2, a, 16'h0000);
    check("high rd", q, 16'hCD00);
    xfer(1'b0, 2'h3, a, 16'h0000);
    check("high wr", q, 16'hCDAB);
  endtask
  // A request with no lane is dropped and changes nothing
  task automatic t_no_lane(input logic [ADDR_W-1:0] a);
    int hits;
    hits = 0;
    req_valid <= 1'b1;
    req <= '{addr: a, wdata: 16'h0000, lanes: 2'h0, write: 1'b1};
    repeat (10) begin
      @(posedge clock);
      hits += int'(ctl.chip_sel_n !== 1'b1);
    end
    req_valid <= 1'b0;
    @(posedge clock);
    check("no lane", 16'(hits), 16'h0000);
    xfer(1'b0, 2'h3, a, 16'h0000);
    check("kept", q, 16'hCDAB);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset();
    for (int g = 0; g < 2; g++) begin
      slow_grade <= (g == 1);
      t_lanes(g == 1 ? 18'h3FFFF : 18'h00000);
      t_no_lane(g == 1 ? 18'h3FFFF : 18'h00000);
    end
    end_sim();
  end
endmodule
`default_nettype wire
